// [rtl/lamp_map.svh]
/*
  Register offsets, field positions, reset values and timing constants of
  the front-panel lamp driver. Assumes a 100 MHz core clock.
*/
`ifndef LAMP_MAP_SVH
`define LAMP_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STARTUP     8'h04
`define REG_STATUS      8'h08
`define REG_INT_STAT    8'h0c
`define REG_INT_MASK    8'h10

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL_FORCE_ERR  0
`define CTRL_RUN        1
`define CTRL_LONG_BLINK 2
`define CTRL_W          3
`define CTRL_RST        3'h0
`define STARTUP_RST     8'h00
`define INT_MASK_RST    16'h0000

// ----------------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------------
`define INT_ERR_RISE    0
`define INT_LINK_LOST   1
`define INT_HART_LSB    8
`define INT_W           16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ     100000000
`define MS_PER_S        1000
`define BLINK_SHORT_MS  100
`define BLINK_LONG_MS   400

`endif

// [rtl/lamp_pkg.sv]
/*
  Types shared by the lamp driver modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lamp_pkg;
  typedef logic [7:0]  chan_vec_t;
  typedef logic [31:0] word_t;
  typedef enum logic {MODE_STARTUP, MODE_RUN} lamp_mode_t;
endpackage

// [rtl/blink_if.sv]
/*
  Carrier between the lamp driver and one channel's blink-off timer.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface blink_if;
  logic start;
  logic long_sel;
  logic active;
  modport timer (input start, input long_sel, output active);
  modport ctrl  (output start, output long_sel, input active);
endinterface
`default_nettype wire

// [rtl/blink_timer.sv]
/*
  Blink-off interval timer for one channel lamp.
  Assumes a one-cycle start pulse in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module blink_timer
  import lamp_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 10,
  parameter int unsigned LONG_CYC  = 40
)
(
  input wire logic clk,
  input wire logic rst_n,
  blink_if.timer   bi
);
  word_t cnt_q;
  word_t cnt_d;
  word_t dur;

  // ----------------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------------
  assign dur       = bi.long_sel ? word_t'(LONG_CYC) : word_t'(SHORT_CYC); // [R12]
  // A fresh completion reloads the count, so the lamp stays off a full interval
  assign cnt_d     = bi.start ? dur : ((cnt_q != 32'h0) ? cnt_q - 32'h1 : cnt_q); // [R14]
  assign bi.active = (cnt_q != 32'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  restart_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    bi.start |=> cnt_q == $past(dur))
    else $error("Blink timer did not reload on start");
  count_end_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    (cnt_q == 32'h1 && !bi.start) |=> !bi.active)
    else $error("Blink timer did not expire");
endmodule
`default_nettype wire

// [rtl/fault_merge.sv]
/*
  Merges the module fault sources into the readable error bit.
  Assumes all sources are synchronous levels in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_merge
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       force_err,
  input  wire logic       link_lost,
  input  wire logic       not_cal,
  input  wire logic [2:0] mem_fail,
  output logic            err
);
  // ----------------------------------------------------------------------
  // Error bit
  // ----------------------------------------------------------------------
  // Auxiliary power is deliberately not an input here
  assign err = force_err // [R4] [R13]
             | link_lost // [R5]
             | not_cal   // [R6]
             | (|mem_fail); // [R7]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  mem_fail_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    (|mem_fail) |-> err)
    else $error("Storage failure not flagged");
  quiet_err_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (!force_err && !link_lost && !not_cal && mem_fail == 3'h0) |-> !err)
    else $error("Error bit set with no fault source");
endmodule
`default_nettype wire

// [rtl/status_lamps.sv]
/*
  Front-panel lamp driver of an eight-channel current-loop input module,
  with a classic Wishbone register slave and a level interrupt.
  Assumes all inputs synchronous to CORE_CLK and one-cycle HART done pulses.
*/
// Design decisions made here: register access over Wishbone and the address map.
// What this block does
// R1: Power lamp follows the supply-good report.
// R2: Communications lamp lit while the controller is exchanging transactions.
// R3: Fault lamp for any internal fault, never for auxiliary power loss alone.
// R4: Force-error control bit lights the fault lamp.
// R5: Loss of controller communication lights the fault lamp.
// R6: Missing calibration lights the fault lamp.
// R7: Flash, EE or RAM diagnostic failure lights the fault lamp.
// R8: Before configuration channel lamps show the firmware startup state.
// R9: After configuration a channel lamp is on while its input is healthy.
// R10: After configuration a channel lamp is off while its input is bad.
// R11: Completed HART exchange on healthy input blinks the lamp off 100 ms.
// R12: A 400 ms blink-off is also available, chosen by a control bit.
// R13: Fault lamp always mirrors the readable error bit.
// R14: Blink intervals counted on the core clock; new completion restarts them.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_map.svh"
module status_lamps
  import lamp_pkg::*;
#(
  parameter int unsigned SHORT_BLINK_CYC = `BLINK_SHORT_MS * (`CLK_FREQ_HZ / `MS_PER_S),
  parameter int unsigned LONG_BLINK_CYC  = `BLINK_LONG_MS * (`CLK_FREQ_HZ / `MS_PER_S)
)
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        PWR_GOOD,
  input  wire logic        AUX_PWR_GOOD,
  input  wire logic        LINK_ACTIVE,
  input  wire logic        LINK_LOST,
  input  wire logic        NOT_CALIBRATED,
  input  wire logic [2:0]  MEM_FAIL,
  input  wire logic [7:0]  CHAN_HEALTHY,
  input  wire logic [7:0]  HART_DONE,
  output logic             PWR_LED,
  output logic             COMM_LED,
  output logic             FAULT_LED,
  output logic      [7:0]  CHAN_LED,
  output logic             IRQ
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`CTRL_W-1:0]  ctrl_q;
  logic [`CTRL_W-1:0]  ctrl_d;
  chan_vec_t           startup_q;
  chan_vec_t           startup_d;
  logic [`INT_W-1:0]   int_stat_q;
  logic [`INT_W-1:0]   int_stat_d;
  logic [`INT_W-1:0]   int_mask_q;
  logic [`INT_W-1:0]   int_mask_d;
  logic [`INT_W-1:0]   int_set;
  logic [`INT_W-1:0]   int_clr;
  logic                ack_q;
  word_t               rdata_q;
  word_t               rd_mux;
  word_t               wmask;
  logic                bus_take;
  logic                wr_take;
  logic                sel_ctrl;
  logic                sel_startup;
  logic                sel_status;
  logic                sel_int_stat;
  logic                sel_int_mask;
  logic                err_bit;
  logic                err_prev_q;
  logic                lost_prev_q;
  logic                pwr_led_q;
  logic                comm_led_q;
  logic                fault_led_q;
  chan_vec_t           chan_led_q;
  chan_vec_t           chan_led_d;
  chan_vec_t           blink_start;
  chan_vec_t           blink_on;
  logic                irq_q;
  lamp_mode_t          mode;

  // ----------------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------------
  // Answer one cycle after the request is seen; ack drops the cycle after
  assign bus_take     = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr_take      = bus_take & WB_WE_I;
  assign sel_ctrl     = (WB_ADR_I == `REG_CTRL);
  assign sel_startup  = (WB_ADR_I == `REG_STARTUP);
  assign sel_status   = (WB_ADR_I == `REG_STATUS);
  assign sel_int_stat = (WB_ADR_I == `REG_INT_STAT);
  assign sel_int_mask = (WB_ADR_I == `REG_INT_MASK);
  assign wmask        = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                         {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Unmapped addresses are acknowledged and read as zero
  assign rd_mux = sel_ctrl     ? {29'h0, ctrl_q} :
                  sel_startup  ? {24'h0, startup_q} :
                  sel_status   ? {8'h0, chan_led_q, CHAN_HEALTHY, 4'h0,
                                  AUX_PWR_GOOD, LINK_ACTIVE, PWR_GOOD, err_bit} : // [R13]
                  sel_int_stat ? {16'h0, int_stat_q} :
                  sel_int_mask ? {16'h0, int_mask_q} :
                                 32'h0;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign ctrl_d     = (wr_take && sel_ctrl) ?
                      ((ctrl_q & ~wmask[`CTRL_W-1:0]) | (WB_DAT_I[`CTRL_W-1:0] & wmask[`CTRL_W-1:0])) :
                      ctrl_q;
  assign startup_d  = (wr_take && sel_startup) ?
                      ((startup_q & ~wmask[7:0]) | (WB_DAT_I[7:0] & wmask[7:0])) : startup_q;
  assign int_mask_d = (wr_take && sel_int_mask) ?
                      ((int_mask_q & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0])) :
                      int_mask_q;

  // ----------------------------------------------------------------------
  // Interrupt status, write one to clear; a new event beats the clear
  // ----------------------------------------------------------------------
  assign int_set    = {HART_DONE, 6'h0, LINK_LOST & ~lost_prev_q, err_bit & ~err_prev_q};
  assign int_clr    = (wr_take && sel_int_stat) ? (WB_DAT_I[15:0] & wmask[15:0]) : 16'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | int_set;

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_q      <= `CTRL_RST;
      startup_q   <= `STARTUP_RST;
      int_mask_q  <= `INT_MASK_RST;
      int_stat_q  <= 16'h0;
      ack_q       <= 1'b0;
      rdata_q     <= 32'h0;
      err_prev_q  <= 1'b0;
      lost_prev_q <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      startup_q   <= startup_d;
      int_mask_q  <= int_mask_d;
      int_stat_q  <= int_stat_d;
      ack_q       <= bus_take;
      rdata_q     <= bus_take ? rd_mux : 32'h0;
      err_prev_q  <= err_bit;
      lost_prev_q <= LINK_LOST;
      irq_q       <= |(int_stat_d & int_mask_d);
    end
  end

  // ----------------------------------------------------------------------
  // Fault sources
  // ----------------------------------------------------------------------
  fault_merge u_fault
  (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .force_err (ctrl_q[`CTRL_FORCE_ERR]),
    .link_lost (LINK_LOST),
    .not_cal   (NOT_CALIBRATED),
    .mem_fail  (MEM_FAIL),
    .err       (err_bit)
  );

  // ----------------------------------------------------------------------
  // Channel lamps and blink timers
  // ----------------------------------------------------------------------
  assign mode = ctrl_q[`CTRL_RUN] ? MODE_RUN : MODE_STARTUP;

  for (genvar i = 0; i < 8; i++)
  begin : g_chan
    blink_if bif();
    assign blink_start[i] = HART_DONE[i] & CHAN_HEALTHY[i]; // [R11]
    assign bif.start      = blink_start[i];
    assign bif.long_sel   = ctrl_q[`CTRL_LONG_BLINK]; // [R12]
    assign blink_on[i]    = bif.active;

    blink_timer #(
      .SHORT_CYC (SHORT_BLINK_CYC), // [R11]
      .LONG_CYC  (LONG_BLINK_CYC)
    ) u_timer
    (
      .clk   (CORE_CLK),
      .rst_n (RESET_N),
      .bi    (bif)
    );

    // Startup pattern first; afterwards health with blink-offs
    assign chan_led_d[i] = (mode == MODE_STARTUP) ? startup_q[i] : // [R8]
                           (CHAN_HEALTHY[i] & ~blink_on[i]); // [R9] [R10] [R11]

    health_off_a: assert property ( // [R10]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (mode == MODE_RUN && !CHAN_HEALTHY[i]) |=> !CHAN_LED[i])
      else $error("Channel lamp lit on bad input");
    chan_on_a: assert property ( // [R9]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (mode == MODE_RUN && CHAN_HEALTHY[i] && !blink_on[i]) |=> CHAN_LED[i])
      else $error("Channel lamp dark on healthy input");
    blink_off_a: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (mode == MODE_RUN && blink_start[i] && SHORT_BLINK_CYC > 1) |=> ##1 !CHAN_LED[i])
      else $error("Channel lamp did not blink off");
  end

  // ----------------------------------------------------------------------
  // Front-panel lamps, all registered
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pwr_led_q   <= 1'b0;
      comm_led_q  <= 1'b0;
      fault_led_q <= 1'b0;
      chan_led_q  <= 8'h00;
    end
    else
    begin
      pwr_led_q   <= PWR_GOOD; // [R1]
      comm_led_q  <= LINK_ACTIVE; // [R2]
      fault_led_q <= err_bit; // [R3] [R13]
      chan_led_q  <= chan_led_d;
    end
  end

  assign PWR_LED   = pwr_led_q;
  assign COMM_LED  = comm_led_q;
  assign FAULT_LED = fault_led_q;
  assign CHAN_LED  = chan_led_q;
  assign IRQ       = irq_q;
  assign WB_ACK_O  = ack_q;
  assign WB_DAT_O  = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  power_lamp_a: assert property (1'b1 |=> PWR_LED == $past(PWR_GOOD)) // [R1]
    else $error("Power lamp does not follow supply good");
  comm_lamp_a: assert property (LINK_ACTIVE |=> COMM_LED) // [R2]
    else $error("Comm lamp dark during activity");
  aux_ignored_a: assert property ( // [R3]
    (!AUX_PWR_GOOD && !ctrl_q[`CTRL_FORCE_ERR] && !LINK_LOST && !NOT_CALIBRATED
     && MEM_FAIL == 3'h0) |=> !FAULT_LED)
    else $error("Fault lamp lit by auxiliary power loss");
  force_fault_a: assert property ( // [R4]
    (wr_take && sel_ctrl && WB_SEL_I[0] && WB_DAT_I[`CTRL_FORCE_ERR]) |=> ##1 FAULT_LED)
    else $error("Force error did not light fault lamp");
  link_fault_a: assert property (LINK_LOST |=> FAULT_LED) // [R5]
    else $error("Link loss did not light fault lamp");
  cal_fault_a: assert property (NOT_CALIBRATED |=> FAULT_LED) // [R6]
    else $error("Missing calibration did not light fault lamp");
  mem_fault_a: assert property ((MEM_FAIL != 3'h0) |=> FAULT_LED) // [R7]
    else $error("Storage failure did not light fault lamp");
  comm_dark_a: assert property (!LINK_ACTIVE |=> !COMM_LED) // [R2]
    else $error("Comm lamp lit with no activity");
  startup_show_a: assert property ( // [R8]
    (mode == MODE_STARTUP && !wr_take) |=> CHAN_LED == $past(startup_q))
    else $error("Startup pattern not shown");
  err_mirror_a: assert property (1'b1 |=> FAULT_LED == $past(err_bit)) // [R13]
    else $error("Fault lamp differs from error bit");
  bus_ack_a: assert property ((WB_CYC_I && WB_STB_I && !ack_q) |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("Wishbone ack not one cycle");
  irq_level_a: assert property (1'b1 |=> IRQ == $past(|(int_stat_d & int_mask_d)))
    else $error("Interrupt out of step with status");

  // ----------------------------------------------------------------------
  // Register bus checks
  // ----------------------------------------------------------------------
  // Read data stays quiet outside ack so a wired-OR read bus stays clean
  rdata_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("Read data driven outside ack");
  ack_req_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("Ack without a request");
  ctrl_write_a: assert property ((wr_take && sel_ctrl && WB_SEL_I[0]) |=> // [R4]
    ctrl_q == $past(WB_DAT_I[`CTRL_W-1:0]))
    else $error("Control write lost");
  startup_write_a: assert property ((wr_take && sel_startup && WB_SEL_I[0]) |=> // [R8]
    startup_q == $past(WB_DAT_I[7:0]))
    else $error("Startup pattern write lost");
  mask_write_a: assert property ((wr_take && sel_int_mask && WB_SEL_I[1:0] == 2'h3) |=>
    int_mask_q == $past(WB_DAT_I[15:0]))
    else $error("Mask write lost");
  rd_ctrl_a: assert property ((bus_take && !WB_WE_I && sel_ctrl) |=>
    WB_DAT_O == {29'h0, $past(ctrl_q)})
    else $error("Control read wrong");
  rd_status_a: assert property ((bus_take && !WB_WE_I && sel_status) |=> // [R13]
    WB_DAT_O[0] == $past(err_bit))
    else $error("Status error bit read wrong");
  rd_unmapped_a: assert property ((bus_take && !WB_WE_I && !sel_ctrl && !sel_startup
    && !sel_status && !sel_int_stat && !sel_int_mask) |=> WB_DAT_O == 32'h0)
    else $error("Unmapped read not zero");

  // ----------------------------------------------------------------------
  // Interrupt checks
  // ----------------------------------------------------------------------
  // Status bits are sticky: only an event or a clear may move them
  stat_keep_a: assert property ((!(wr_take && sel_int_stat) && int_set == 16'h0) |=>
    $stable(int_stat_q))
    else $error("Interrupt status moved on its own");
  w1c_clear_a: assert property ((wr_take && sel_int_stat && WB_SEL_I[1]
    && WB_DAT_I[`INT_HART_LSB] && !HART_DONE[0]) |=> !int_stat_q[`INT_HART_LSB])
    else $error("Write one did not clear status");
  set_wins_a: assert property ((HART_DONE != 8'h00) |=>
    (int_stat_q[15:8] & $past(HART_DONE)) == $past(HART_DONE))
    else $error("Completion event lost");
  link_rise_a: assert property ((LINK_LOST && !lost_prev_q) |=> int_stat_q[`INT_LINK_LOST])
    else $error("Link loss event lost");
  err_rise_a: assert property ((err_bit && !err_prev_q) |=> int_stat_q[`INT_ERR_RISE])
    else $error("Error rise event lost");
  irq_quiet_a: assert property ((int_mask_q == 16'h0 && !(wr_take && sel_int_mask)) |=> !IRQ)
    else $error("Interrupt raised while all masked");

  blink_seen_c: cover property (blink_start != 8'h00 && mode == MODE_RUN);
  force_seen_c: cover property (ctrl_q[`CTRL_FORCE_ERR] ##1 FAULT_LED);
  long_blink_c: cover property (ctrl_q[`CTRL_LONG_BLINK] && blink_start != 8'h00);
  irq_seen_c:   cover property (IRQ);
  w1c_seen_c:   cover property (wr_take && sel_int_stat);
endmodule
`default_nettype wire

// [sim/lamp_panel.sv]
/*
  Operator's view of the eight channel lamps: measures each dark spell.
  Assumes lamps are registered on the rising edge, so it looks on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lamp_panel
  import lamp_pkg::*;
(
  input  wire logic      clk,
  input  wire chan_vec_t lamp,
  output int             dark_len [8]
);
  // ----------------------------------------------------------------------
  // Dark spell length, latched when the lamp relights
  // ----------------------------------------------------------------------
  int run [8];
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      run[i] = 0;
      dark_len[i] = 0;
    end
  end
  always @(negedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (lamp[i] !== 1'b1)
        run[i] = run[i] + 1;
      else if (run[i] != 0)
      begin
        dark_len[i] = run[i];
        run[i] = 0;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/status_lamps_tb.sv]
/*
  Self-checking bench of the lamp driver: Wishbone tasks plus lamp checks.
  Assumes the blink counts are shortened to 8 and 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lamp_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module status_lamps_tb;
  import lamp_pkg::*;
  logic      clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, hart = 0, healthy = 0, led;
  logic [3:0] sel = 0;
  word_t     wdat = 0, rdat;
  logic      ack, pwr = 0, aux = 0, act = 0, lost = 0, ncal = 0;
  logic [2:0] memf = 0;
  logic      pwr_led, comm_led, fault_led, irq;
  int        dark [8];
  int        n_errors = 0, n_tests = 0;

  always #5 clk = ~clk;

  status_lamps #(.SHORT_BLINK_CYC(8), .LONG_BLINK_CYC(20)) i_status_lamps (
    .CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .PWR_GOOD(pwr), .AUX_PWR_GOOD(aux),
    .LINK_ACTIVE(act), .LINK_LOST(lost), .NOT_CALIBRATED(ncal),
    .MEM_FAIL(memf), .CHAN_HEALTHY(healthy), .HART_DONE(hart),
    .PWR_LED(pwr_led), .COMM_LED(comm_led), .FAULT_LED(fault_led),
    .CHAN_LED(led), .IRQ(irq));
  lamp_panel i_lamp_panel (.clk(clk), .lamp(led), .dark_len(dark));

  // ----------------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------------
  // Request held until ack is sampled high at a rising edge; data taken there
  task wb(input logic w, input logic [7:0] a, input word_t d, output word_t q);
    int t;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    t = 0;
    do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task wr(input logic [7:0] a, input word_t d);
    word_t x;
    wb(1'b1, a, d, x);
  endtask
  task rd(input logic [7:0] a, input word_t e);
    word_t x;
    wb(1'b0, a, 32'h0, x);
    `CHK(x, e)
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task pulse(input logic [7:0] m);
    @(posedge clk) hart <= m;
    @(posedge clk) hart <= 8'h00;
  endtask
  // Force error goes through the control register, the rest are pins
  task fault(input int k, input logic v);
    case (k)
      0: wr(`REG_CTRL, {31'h0, v});
      1: @(posedge clk) lost <= v;
      2: @(posedge clk) ncal <= v;
      default: @(posedge clk) memf <= v ? 3'h1 << (k - 3) : 3'h0;
    endcase
  endtask

  task conclude;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog: the tests need well under a thousand cycles
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude;
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(`REG_CTRL, 32'h0);
    rd(`REG_STARTUP, 32'h0);
    rd(`REG_INT_MASK, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    for (int v = 0; v < 4; v++)
    begin
      @(posedge clk) {act, pwr} <= v[1:0];
      settle(2);
      `CHK({comm_led, pwr_led}, v[1:0])
    end
    @(posedge clk) aux <= 1;
    rd(`REG_STATUS, 32'he);
    $display("test power done");
    @(posedge clk) aux <= 0;
    settle(3);
    `CHK(fault_led, 1'b0)
    for (int k = 0; k < 6; k++)
    begin
      fault(k, 1'b1);
      settle(3);
      `CHK(fault_led, 1'b1)
      rd(`REG_STATUS, 32'h7);
      fault(k, 1'b0);
      settle(3);
      `CHK(fault_led, 1'b0)
    end
    @(posedge clk) aux <= 1;
    $display("test fault done");
    wr(`REG_STARTUP, 32'ha5);
    @(posedge clk) healthy <= 8'h0f;
    settle(2);
    `CHK(led, 8'ha5)
    wr(`REG_CTRL, 32'h2);
    @(posedge clk) healthy <= 8'h3c;
    settle(2);
    `CHK(led, 8'h3c)
    @(posedge clk) healthy <= 8'hfd;
    settle(2);
    `CHK(led, 8'hfd)
    $display("test channel done");
    wr(`REG_INT_STAT, 32'hffff);
    wr(`REG_INT_MASK, 32'h100);
    pulse(8'h01);
    settle(30);
    `CHK(dark[0], 8)
    `CHK(irq, 1'b1)
    rd(`REG_INT_STAT, 32'h100);
    wr(`REG_INT_STAT, 32'h100);
    settle(1);
    `CHK(irq, 1'b0)
    pulse(8'h01);
    repeat (3) @(posedge clk);
    pulse(8'h01);
    settle(40);
    `CHK(dark[0], 13)
    pulse(8'h02);
    settle(3);
    `CHK(led, 8'hfd)
    wr(`REG_CTRL, 32'h6);
    pulse(8'h01);
    settle(40);
    `CHK(dark[0], 20)
    $display("test blink done");
    wr(`REG_INT_STAT, 32'hffff);
    wr(`REG_INT_MASK, 32'h0);
    @(posedge clk) lost <= 1;
    settle(4);
    `CHK(irq, 1'b0)
    rd(`REG_INT_STAT, 32'h3);
    wr(`REG_INT_MASK, 32'h2);
    settle(1);
    `CHK(irq, 1'b1)
    @(posedge clk) lost <= 0;
    wr(`REG_INT_STAT, 32'h3);
    settle(1);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    conclude;
  end
endmodule
`undef CHK
`default_nettype wire
